//--- logic/pmc_pkg.sv
// package: modes, control field layout and carriers for the power mode controller
package pmc_pkg;
  localparam int PMC_NUM_WAKE = 32;
  localparam int PMC_SYNC_STAGES = 3;
  // control field positions inside pll_control_reg
  localparam int PMC_CTL_BYPASS = 0;
  localparam int PMC_CTL_PLL_OFF = 1;
  localparam int PMC_CTL_WIDTH = 2;
  localparam logic [PMC_CTL_WIDTH-1:0] PMC_CTL_RST = 2'h0;
  localparam logic [PMC_NUM_WAKE-1:0] PMC_WAKE_EN_RST = 32'h0;

  // one-hot operating modes
  typedef enum logic [4:0] {
    PMC_FULL_ON    = 5'h01,
    PMC_ACTIVE     = 5'h02,
    PMC_SLEEP      = 5'h04,
    PMC_DEEP_SLEEP = 5'h08,
    PMC_HIBERNATE  = 5'h10
  } pmc_mode_t;

  // software mode request encoding
  typedef enum logic [2:0] {
    PMC_REQ_FULL_ON    = 3'h0,
    PMC_REQ_ACTIVE     = 3'h1,
    PMC_REQ_SLEEP      = 3'h2,
    PMC_REQ_DEEP_SLEEP = 3'h3,
    PMC_REQ_HIBERNATE  = 3'h4
  } pmc_req_t;

  // clock and power controls toward the clock tree
  typedef struct packed {
    logic pll_en;
    logic pll_bypass;
    logic core_clk_en;
    logic sys_clk_en;
    logic core_pwr_on;
    logic l1_dma_grant;
  } pmc_ctl_t;
endpackage

//--- logic/pmc_power_mode_controller.sv
// power mode controller: five operating modes, wakeup exits, glitch-free clock gating
// What this block does
// - five operating modes are kept, each with its own clock and power profile.
// - full-on runs the PLL enabled and not bypassed.
// - reset release lands in full-on mode.
// - active keeps the PLL enabled unless the PLL-disable bit is set, and bypassed, clocks from the input clock.
// - active mode keeps DMA to level-one memory granted.
// - in active mode the PLL-disable bit switches the PLL control input off.
// - sleep stops the core clock but keeps the PLL and system clock running.
// - an enabled wakeup in sleep goes to full-on if bypass is clear, else active.
// - sleep withholds system DMA access to level-one memory.
// - deep sleep stops core and system clocks, only async peripherals run.
// - deep sleep leaves only by RTC interrupt to active, or reset to full-on.
// - hibernate removes core supply and all core and system clocks.
// - hibernate wakeup requests the full hardware reset sequence.
`timescale 1ns/10ps
module pmc_power_mode_controller #(
  parameter int NUM_WAKE = pmc_pkg::PMC_NUM_WAKE
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // pll_control_reg fields and wakeup_enable_regs from software
  input wire logic [pmc_pkg::PMC_CTL_WIDTH-1:0] pll_control_reg_i,
  input wire logic [NUM_WAKE-1:0] wakeup_enable_regs_i,
  // mode request from the core
  input wire logic mode_req_i,
  input wire pmc_pkg::pmc_req_t mode_req_sel_i,
  input wire logic core_idle_i,
  // asynchronous wakeup sources
  input wire logic [NUM_WAKE-1:0] wakeup_src_i,
  input wire logic rtc_irq_i,
  input wire logic hib_wake_i,
  // clock tree and power outputs
  output pmc_pkg::pmc_ctl_t ctl_o,
  output pmc_pkg::pmc_mode_t mode_o,
  output logic mode_req_ack_o,
  output logic hw_reset_req_o,
  // clocks
  input wire logic input_clock_i,
  input wire logic pll_clock_i,
  output logic core_clock_o,
  output logic sys_clock_o
);
  import pmc_pkg::*;

  // ==========================================================
  // input synchronisers
  localparam int SW = NUM_WAKE + 2;
  logic [SW-1:0] sync1_ff, sync2_ff, sync3_ff;
  logic [SW-1:0] stable_ff;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      stable_ff <= '0;
    end else begin
      sync1_ff <= {hib_wake_i, rtc_irq_i, wakeup_src_i};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      // a change counts once stages two and three agree
      for (int i = 0; i < SW; i++) begin
        if (sync2_ff[i] == sync3_ff[i]) begin
          stable_ff[i] <= sync3_ff[i];
        end
      end
    end
  end

  logic [NUM_WAKE-1:0] wake_lvl;
  logic rtc_lvl;
  logic hib_lvl;
  logic wake_hit;
  assign wake_lvl = stable_ff[NUM_WAKE-1:0];
  assign rtc_lvl = stable_ff[NUM_WAKE];
  assign hib_lvl = stable_ff[NUM_WAKE+1];
  assign wake_hit = |(wake_lvl & wakeup_enable_regs_i);

  // ==========================================================
  // mode state machine
  pmc_mode_t mode_ff, nxt_mode;
  logic bypass;
  logic pll_off;
  assign bypass = pll_control_reg_i[PMC_CTL_BYPASS];
  assign pll_off = pll_control_reg_i[PMC_CTL_PLL_OFF];

  // requests only count while the core has idled
  logic req_ok;
  assign req_ok = mode_req_i && core_idle_i;

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      PMC_FULL_ON, PMC_ACTIVE: begin
        if (req_ok) begin
          case (mode_req_sel_i)
            PMC_REQ_FULL_ON: nxt_mode = PMC_FULL_ON;
            PMC_REQ_ACTIVE: nxt_mode = PMC_ACTIVE;
            PMC_REQ_SLEEP: nxt_mode = PMC_SLEEP;
            PMC_REQ_DEEP_SLEEP: nxt_mode = PMC_DEEP_SLEEP;
            PMC_REQ_HIBERNATE: nxt_mode = PMC_HIBERNATE;
            default: nxt_mode = mode_ff;
          endcase
        end
      end
      PMC_SLEEP: begin
        if (wake_hit) begin
          nxt_mode = bypass ? PMC_ACTIVE : PMC_FULL_ON;
        end
      end
      PMC_DEEP_SLEEP: begin
        if (rtc_lvl) begin
          nxt_mode = PMC_ACTIVE;
        end
      end
      // hibernate is left only through the reset sequence
      PMC_HIBERNATE: nxt_mode = PMC_HIBERNATE;
      default: nxt_mode = PMC_FULL_ON;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_ff <= PMC_FULL_ON;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  logic ack_ff;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req_ok && (mode_ff == PMC_FULL_ON || mode_ff == PMC_ACTIVE);
    end
  end
  assign mode_req_ack_o = ack_ff;

  // hibernate wake holds a reset request until reset clears this block
  logic hw_rst_ff;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hw_rst_ff <= 1'b0;
    end else if (mode_ff == PMC_HIBERNATE && hib_lvl) begin
      hw_rst_ff <= 1'b1;
    end
  end
  assign hw_reset_req_o = hw_rst_ff;

  // ==========================================================
  // clock and power controls per mode
  pmc_ctl_t ctl_ff, nxt_ctl;
  always_comb begin
    nxt_ctl = '0;
    case (mode_ff)
      PMC_FULL_ON: begin
        // assumed: software has re-enabled the PLL before this request
        nxt_ctl = '{pll_en: 1'b1, pll_bypass: 1'b0, core_clk_en: 1'b1,
                    sys_clk_en: 1'b1, core_pwr_on: 1'b1, l1_dma_grant: 1'b1};
      end
      PMC_ACTIVE: begin
        nxt_ctl = '{pll_en: !pll_off, pll_bypass: 1'b1, core_clk_en: 1'b1,
                    sys_clk_en: 1'b1, core_pwr_on: 1'b1, l1_dma_grant: 1'b1};
      end
      PMC_SLEEP: begin
        nxt_ctl = '{pll_en: 1'b1, pll_bypass: bypass, core_clk_en: 1'b0,
                    sys_clk_en: 1'b1, core_pwr_on: 1'b1, l1_dma_grant: 1'b0};
      end
      PMC_DEEP_SLEEP: begin
        nxt_ctl = '{pll_en: 1'b0, pll_bypass: 1'b1, core_clk_en: 1'b0,
                    sys_clk_en: 1'b0, core_pwr_on: 1'b1, l1_dma_grant: 1'b0};
      end
      PMC_HIBERNATE: begin
        nxt_ctl = '{pll_en: 1'b0, pll_bypass: 1'b1, core_clk_en: 1'b0,
                    sys_clk_en: 1'b0, core_pwr_on: 1'b0, l1_dma_grant: 1'b0};
      end
      default: nxt_ctl = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl_ff <= '{pll_en: 1'b1, pll_bypass: 1'b0, core_clk_en: 1'b1,
                  sys_clk_en: 1'b1, core_pwr_on: 1'b1, l1_dma_grant: 1'b1};
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end
  assign ctl_o = ctl_ff;
  assign mode_o = mode_ff;

  // ==========================================================
  // glitch-free clock gating: enables latched while the source is low
  // mux select trails the bypass request by a cycle and the gates stay
  // shut a cycle on either side, so a source switch never cuts a pulse
  logic mux_sel_ff;
  logic mux_sel_old_ff;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mux_sel_ff <= 1'b0;
      mux_sel_old_ff <= 1'b0;
    end else begin
      mux_sel_ff <= ctl_ff.pll_bypass;
      mux_sel_old_ff <= mux_sel_ff;
    end
  end
  logic sel_quiet;
  assign sel_quiet = (mux_sel_ff == ctl_ff.pll_bypass) && (mux_sel_old_ff == mux_sel_ff);
  logic src_clk;
  assign src_clk = mux_sel_ff ? input_clock_i : pll_clock_i;
  logic core_gate_lat, sys_gate_lat;
  always_latch begin
    if (!src_clk) begin
      core_gate_lat = ctl_ff.core_clk_en && sel_quiet;
      sys_gate_lat = ctl_ff.sys_clk_en && sel_quiet;
    end
  end
  // limitation: each source must keep toggling so that shut gates get latched
  assign core_clock_o = src_clk & core_gate_lat;
  assign sys_clock_o = src_clk & sys_gate_lat;
endmodule // pmc_power_mode_controller

//--- verif/pmc_checker.sv
// checker: clock and power profile assertions for the mode controller
`timescale 1ns/10ps
module pmc_checker #(parameter int NUM_WAKE = 32) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // requests and wakeups
  input wire logic [pmc_pkg::PMC_CTL_WIDTH-1:0] pll_control_reg_i,
  input wire logic [NUM_WAKE-1:0] wakeup_enable_regs_i,
  input wire logic mode_req_i,
  input wire pmc_pkg::pmc_req_t mode_req_sel_i,
  input wire logic core_idle_i,
  input wire logic [NUM_WAKE-1:0] wakeup_src_i,
  // results
  input wire pmc_pkg::pmc_ctl_t ctl_o,
  input wire pmc_pkg::pmc_mode_t mode_o,
  input wire logic mode_req_ack_o
);
  import pmc_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ====
  // properties
  sequence run_s; mode_o inside {PMC_FULL_ON, PMC_ACTIVE}; endsequence
  sequence take_s; run_s ##0 mode_req_i && core_idle_i && mode_req_sel_i == PMC_REQ_SLEEP; endsequence
  chk_reset_full_on: assert property ($fell(sys_rst_i) |-> mode_o == PMC_FULL_ON)
    else $error("not full-on after reset");
  chk_full_clocks: assert property ($past(mode_o) == PMC_FULL_ON |-> ctl_o.pll_en && !ctl_o.pll_bypass)
    else $error("full-on pll wrong");
  chk_active_clocks: assert property ($past(mode_o) == PMC_ACTIVE |->
    ctl_o.pll_bypass && ctl_o.core_clk_en && ctl_o.sys_clk_en && ctl_o.l1_dma_grant)
    else $error("active clocks wrong");
  chk_pll_off: assert property ($past(mode_o) == PMC_ACTIVE |->
    ctl_o.pll_en == !$past(pll_control_reg_i[PMC_CTL_PLL_OFF])) else $error("pll off ignored");
  chk_sleep_clocks: assert property ($past(mode_o) == PMC_SLEEP |->
    ctl_o.pll_en && !ctl_o.core_clk_en && ctl_o.sys_clk_en && !ctl_o.l1_dma_grant)
    else $error("sleep clocks wrong");
  chk_deep_clocks: assert property ($past(mode_o) == PMC_DEEP_SLEEP |->
    !(ctl_o.core_clk_en || ctl_o.sys_clk_en)) else $error("deep sleep clock running");
  chk_hib_power: assert property ($past(mode_o) == PMC_HIBERNATE |->
    !(ctl_o.core_pwr_on || ctl_o.core_clk_en || ctl_o.sys_clk_en)) else $error("hibernate powered");
  chk_req_taken: assert property (take_s |=> mode_o == PMC_SLEEP && mode_req_ack_o)
    else $error("request not taken");
  chk_no_idle: assert property (run_s ##0 mode_req_i && !core_idle_i |=> $stable(mode_o))
    else $error("request taken while busy");
  chk_wake_exit: assert property (mode_o == PMC_SLEEP && |(wakeup_src_i & wakeup_enable_regs_i)
    |-> ##[1:8] mode_o != PMC_SLEEP) else $error("sleep not left");
endmodule // pmc_checker
bind pmc_power_mode_controller pmc_checker #(.NUM_WAKE(NUM_WAKE)) pmc_checker_inst (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pll_control_reg_i(pll_control_reg_i),
  .wakeup_enable_regs_i(wakeup_enable_regs_i), .mode_req_i(mode_req_i),
  .mode_req_sel_i(mode_req_sel_i), .core_idle_i(core_idle_i), .wakeup_src_i(wakeup_src_i),
  .ctl_o(ctl_o), .mode_o(mode_o), .mode_req_ack_o(mode_req_ack_o));

//--- verif/pmc_power_mode_controller_tb.sv
// self-checking bench for the power mode controller
`timescale 1ns/10ps
module pmc_power_mode_controller_tb;
  import pmc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] pll_reg = 2'h0;
  logic [31:0] wake_en = 32'h0;
  logic req = 1'b0;
  pmc_req_t sel = PMC_REQ_FULL_ON;
  logic idle = 1'b0;
  logic go = 1'b0;
  logic [5:0] line = 6'h0;
  logic [31:0] src;
  logic rtc, hib, ack, hw_rst, core_clk, sys_clk;
  pmc_ctl_t ctl;
  pmc_mode_t mode;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  int m = 0;
  int idx = 0;
  int seed = 9;
  always #12.5 ref_clk_i = ~ref_clk_i;
  pmc_power_mode_controller pmc_power_mode_controller_inst (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pll_control_reg_i(pll_reg),
    .wakeup_enable_regs_i(wake_en), .mode_req_i(req), .mode_req_sel_i(sel),
    .core_idle_i(idle), .wakeup_src_i(src), .rtc_irq_i(rtc), .hib_wake_i(hib),
    .ctl_o(ctl), .mode_o(mode), .mode_req_ack_o(ack), .hw_reset_req_o(hw_rst),
    .input_clock_i(ref_clk_i), .pll_clock_i(ref_clk_i), .core_clock_o(core_clk),
    .sys_clock_o(sys_clk));
  pmc_wake_model pmc_wake_model_inst (.ref_clk_i(ref_clk_i), .go_i(go), .line_i(line),
    .wakeup_src_o(src), .rtc_irq_o(rtc), .hib_wake_o(hib));
  // ====
  // tasks
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic settle();
    logic [5:0] k;
    // gates reopen two cycles after a bypass change
    repeat (4) @(posedge ref_clk_i);
    #1;
    k = (m > 2) ? 6'h2E : 6'h3F;
    check(32'(mode), 32'(5'h01 << m));
    case (m)
      0: check(32'(ctl), 32'h2F);
      1: check(32'(ctl), 32'({~pll_reg[1], 5'h1F}));
      2: check(32'(ctl), 32'({1'b1, pll_reg[0], 4'h6}));
      3: check(32'(ctl & k), 32'h02);
      default: check(32'(ctl & k), 32'h00);
    endcase
    check(32'(core_clk), 32'(m < 2));
    check(32'(sys_clk), 32'(m < 3));
    $display("step done at %0t", $time);
  endtask
  task automatic ask(pmc_req_t s, logic i, logic [1:0] r);
    logic ok;
    ok = i && m < 2;
    @(posedge ref_clk_i);
    sel <= s;
    idle <= i;
    pll_reg <= r;
    req <= 1'b1;
    @(posedge ref_clk_i);
    req <= 1'b0;
    // ack stands for the one cycle after the taking edge
    #1;
    check(32'(ack), 32'(ok));
    // an undefined selection is acknowledged but leaves the mode alone
    if (ok && s < 5) m = int'(s);
    settle();
  endtask
  task automatic wake(int ln, int nm);
    @(posedge ref_clk_i);
    wake_en <= 32'h1 << idx;
    line <= 6'(ln);
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    // let the synchronised level drain before the next sleep request
    repeat (12) @(posedge ref_clk_i);
    m = nm;
    settle();
  endtask
  task automatic rst();
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    m = 0;
    settle();
    check(32'(hw_rst), 32'h0);
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    rst();
    ask(PMC_REQ_SLEEP, 1'b0, 2'h0);
    ask(pmc_req_t'(3'h5), 1'b1, 2'h0);
    ask(PMC_REQ_ACTIVE, 1'b1, 2'h0);
    ask(PMC_REQ_SLEEP, 1'b0, 2'h3);
    for (int b = 0; b < 2; b++) begin
      idx = $unsigned($random(seed)) % 32;
      ask(PMC_REQ_SLEEP, 1'b1, 2'(b));
      ask(PMC_REQ_ACTIVE, 1'b1, 2'(b));
      wake(idx ^ 1, 2);
      wake(idx, b);
    end
    ask(PMC_REQ_FULL_ON, 1'b1, 2'h0);
    ask(PMC_REQ_DEEP_SLEEP, 1'b1, 2'h0);
    wake(idx, 3);
    wake(32, 1);
    ask(PMC_REQ_HIBERNATE, 1'b1, 2'h0);
    wake(33, 4);
    check(32'(hw_rst), 32'h1);
    rst();
    summarize();
  end
endmodule // pmc_power_mode_controller_tb

//--- verif/pmc_wake_model.sv
// wakeup source model: raises one chosen line for a set time
`timescale 1ns/10ps
module pmc_wake_model (
  // control
  input wire logic ref_clk_i,
  input wire logic go_i,
  input wire logic [5:0] line_i,
  // wakeup lines: 0-31 sources, 32 rtc, 33 hibernate wake
  output logic [31:0] wakeup_src_o,
  output logic rtc_irq_o,
  output logic hib_wake_o
);
  // ====
  // event hold
  logic [3:0] left_ff = 4'h0;
  logic [5:0] line_ff = 6'h0;
  always_ff @(posedge ref_clk_i) begin
    if (go_i) begin
      left_ff <= 4'hC;
      line_ff <= line_i;
    end else if (left_ff != 4'h0) begin
      left_ff <= left_ff - 4'h1;
    end
  end
  // level events, long enough to pass the wakeup synchronisers
  assign wakeup_src_o = (left_ff != 4'h0 && !line_ff[5]) ? 32'h1 << line_ff[4:0] : 32'h0;
  assign rtc_irq_o = left_ff != 4'h0 && line_ff == 6'h20;
  assign hib_wake_o = left_ff != 4'h0 && line_ff == 6'h21;
endmodule // pmc_wake_model
